/* sbc_regs_pkg.sv */
// Package of constants for the serial register bank of the system basis device
package sbc_regs_pkg;
  localparam int FRAME_W = 16;
  localparam logic [1:0] SEL_SPECIAL = 2'h1;
  localparam logic [1:0] SEL_SCRATCH0 = 2'h2;
  localparam logic [1:0] SEL_SCRATCH1 = 2'h3;
  localparam int SEL_HI = 15;
  localparam int SEL_LO = 14;
  localparam int RRS_BIT = 13;
  localparam int NOWR_BIT = 12;
  localparam int IDC_BIT = 11;
  localparam int SWDEV_BIT = 9;
  localparam int ERROR_PIN_EMULATION_BIT = 8;
  localparam int WATCHDOG_PRESCALER_FIELD_HI = 6;
  localparam int WATCHDOG_PRESCALER_FIELD_LO = 5;
  localparam int V1TH_HI = 4;
  localparam int V1TH_LO = 3;
  // Writable special mode bits: 9, 8, 6..3; reserved bits stay zero
  localparam logic [11:0] SPECIAL_MASK = 12'h378;
  localparam logic [11:0] SPECIAL_RST = 12'h000;
  localparam logic [11:0] SCRATCH_RST = 12'h000;
  localparam logic [3:0] CAN_FAILURE_DIAGNOSIS_CODE_OK = 4'h0;
  // Prescale factors in half units: 1, 1.5, 2.5, 3.5
  localparam logic [2:0] WATCHDOG_PRESCALER_FIELD_X1 = 3'h2;
  localparam logic [2:0] WATCHDOG_PRESCALER_FIELD_X1P5 = 3'h3;
  localparam logic [2:0] WATCHDOG_PRESCALER_FIELD_X2P5 = 3'h5;
  localparam logic [2:0] WATCHDOG_PRESCALER_FIELD_X3P5 = 3'h7;
  // Threshold fractions in tenths of nominal
  localparam logic [3:0] V1TH_90 = 4'h9;
  localparam logic [3:0] V1TH_80 = 4'h8;
  localparam logic [3:0] V1TH_70 = 4'h7;
  localparam logic [4:0] BITCNT_FULL = 5'h10;
endpackage : sbc_regs_pkg

/* sbc_frame_rx.sv */
// Serial frame shifter: samples the link clock and shifts in/out 16 bits
`timescale 1ns/1ps
module sbc_frame_rx (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic csn_i,
  input wire logic mosi_i,
  input wire logic [15:0] reply_i,
  output logic miso_o,
  output logic frame_ok_o,
  output logic [15:0] frame_o
);
  // Two-stage synchronisers for all pins
  logic [1:0] sck_s_ff, csn_s_ff, mosi_s_ff;
  logic sck_d_ff, csn_d_ff;
  logic [15:0] sh_ff, nxt_sh;
  logic [15:0] tx_ff, nxt_tx;
  logic [4:0] cnt_ff, nxt_cnt;
  logic miso_ff, nxt_miso;
  logic ok_ff, nxt_ok;
  logic [15:0] fr_ff, nxt_fr;
  logic rise, fall, start, stop;

  assign rise = sck_s_ff[1] & ~sck_d_ff;
  assign fall = ~sck_s_ff[1] & sck_d_ff;
  assign start = ~csn_s_ff[1] & csn_d_ff;
  assign stop = csn_s_ff[1] & ~csn_d_ff;

  // Shift on rising edge, drive on falling; frame checked on deselect
  always_comb begin
    nxt_sh = sh_ff;
    nxt_tx = tx_ff;
    nxt_cnt = cnt_ff;
    nxt_miso = miso_ff;
    nxt_ok = 1'b0;
    nxt_fr = fr_ff;
    if (start) begin
      // Reply is captured at frame start and its MSB presented at once
      nxt_tx = {reply_i[14:0], 1'b0};
      nxt_miso = reply_i[15];
      nxt_cnt = '0;
    end else if (!csn_s_ff[1]) begin
      if (rise) begin
        nxt_sh = {sh_ff[14:0], mosi_s_ff[1]};
        // Saturate so long frames are still rejected
        if (cnt_ff != 5'h1f) begin
          nxt_cnt = cnt_ff + 5'h01;
        end
      end
      if (fall) begin
        nxt_miso = tx_ff[15];
        nxt_tx = {tx_ff[14:0], 1'b0};
      end
    end
    if (stop && cnt_ff == sbc_regs_pkg::BITCNT_FULL) begin
      nxt_ok = 1'b1; // [RULE_19]
      nxt_fr = sh_ff;
    end
  end

  // State registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_s_ff <= '0;
      csn_s_ff <= 2'h3;
      mosi_s_ff <= '0;
      sck_d_ff <= 1'b0;
      csn_d_ff <= 1'b1;
      sh_ff <= '0;
      tx_ff <= '0;
      cnt_ff <= '0;
      miso_ff <= 1'b0;
      ok_ff <= 1'b0;
      fr_ff <= '0;
    end else begin
      sck_s_ff <= {sck_s_ff[0], sck_i};
      csn_s_ff <= {csn_s_ff[0], csn_i};
      mosi_s_ff <= {mosi_s_ff[0], mosi_i};
      sck_d_ff <= sck_s_ff[1];
      csn_d_ff <= csn_s_ff[1];
      sh_ff <= nxt_sh;
      tx_ff <= nxt_tx;
      cnt_ff <= nxt_cnt;
      miso_ff <= nxt_miso;
      ok_ff <= nxt_ok;
      fr_ff <= nxt_fr;
    end
  end

  assign miso_o = miso_ff;
  assign frame_ok_o = ok_ff;
  assign frame_o = fr_ff;
endmodule : sbc_frame_rx

/* sbc_special_gp_regs.sv */
// Special mode and user scratch registers of the system basis device
`timescale 1ns/1ps
// Function
// [RULE_01] Select bits 01 address special mode register
// [RULE_02] Bit 13 picks interrupt-enable or special readback
// [RULE_03] Bit 12 set: readback only, no write
// [RULE_04] Host writes zeros to reserved special bits
// [RULE_05] Bit 9 starts software development mode
// [RULE_06] Emulation on: enable pin high iff code 0000
// [RULE_07] Emulation off: enable pin keeps normal function
// [RULE_08] Prescaler codes scale by 1,1.5,2.5,3.5
// [RULE_09] Threshold codes: 0.9, 0.8, 0.7, 0.9
// [RULE_10] Two 12-bit scratch registers with readback
// [RULE_11] Power-up loads ID code, clears ID flag
// [RULE_12] Any scratch-zero write sets ID flag
// [RULE_13] Flag selects user data or ID code
// [RULE_14] Select 10 is scratch zero, readback select
// [RULE_15] Scratch zero no-write flag blocks update
// [RULE_16] Select 11 is scratch one, readback select
// [RULE_17] Scratch one written only when flag clear
// [RULE_18] Interface failure disables LIN transmitter automatically
// [RULE_19] Only complete 16-bit frames write registers
module sbc_special_gp_regs #(
  // Identification code; value is arbitrary
  parameter logic [10:0] ID_CODE = 11'h05a
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic sck_i,
  input wire logic csn_i,
  input wire logic mosi_i,
  input wire logic [15:0] int_en_fb_i,
  input wire logic [15:0] sys_cfg_fb_i,
  input wire logic [15:0] phy_ctl_fb_i,
  input wire logic [3:0] can_failure_diagnosis_code_i,
  input wire logic en_normal_i,
  input wire logic lin_tx_disable_bit_i,
  input wire logic lin_if_fail_i,
  input wire logic lin_rx_valid_i,
  output logic miso_o,
  output logic en_pin_o,
  output logic sw_dev_mode_init_o,
  output logic [2:0] wd_scale_half_o,
  output logic [3:0] v1_thresh_tenth_o,
  output logic lin_tx_enable_o
);
  logic [1:0] rst_s_ff;
  logic rst_n;
  logic frame_ok;
  logic [15:0] frame;
  logic [15:0] reply;
  logic [1:0] last_sel_ff, nxt_last_sel;
  logic last_rrs_ff, nxt_last_rrs;
  logic [11:0] special_ff, nxt_special;
  logic [10:0] user_bits_zero_ff, nxt_user_bits_zero;
  logic idc_ff, nxt_idc;
  logic [11:0] user_bits_one_ff, nxt_user_bits_one;
  logic en_ff, nxt_en;
  logic swdev_ff, nxt_swdev;
  logic [2:0] wd_ff, nxt_wd;
  logic [3:0] v1_ff, nxt_v1;
  logic lin_blk_ff, nxt_lin_blk;
  logic ltc_seen_ff, nxt_ltc_seen;
  logic lin_en_ff, nxt_lin_en;
  logic [1:0] can_s0_ff, can_s1_ff;
  logic [3:0] can_failure_diagnosis_code_s0_ff, can_failure_diagnosis_code_s1_ff;
  logic [1:0] ltc_s_ff, fail_s_ff, rxv_s_ff;
  logic [1:0] sel;
  logic readback_source_select, nowr;

  // Reset released through two flip-flops
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s_ff <= 2'h0;
    end else begin
      rst_s_ff <= {rst_s_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_s_ff[1];

  // Frame shifter on the sampled link clock
  sbc_frame_rx u_rx (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .sck_i(sck_i),
    .csn_i(csn_i),
    .mosi_i(mosi_i),
    .reply_i(reply),
    .miso_o(miso_o),
    .frame_ok_o(frame_ok),
    .frame_o(frame)
  );

  assign sel = frame[sbc_regs_pkg::SEL_HI:sbc_regs_pkg::SEL_LO];
  assign readback_source_select = frame[sbc_regs_pkg::RRS_BIT];
  assign nowr = frame[sbc_regs_pkg::NOWR_BIT];

  // Reply for next frame follows the previous frame's selection
  always_comb begin
    reply = 16'h0000;
    case (last_sel_ff)
      sbc_regs_pkg::SEL_SPECIAL: begin
        reply = last_rrs_ff ? {last_sel_ff, 2'h0, special_ff}
                            : int_en_fb_i; // [RULE_02]
      end
      sbc_regs_pkg::SEL_SCRATCH0: begin
        reply = last_rrs_ff ? {last_sel_ff, 2'h0, idc_ff,
                               user_bits_zero_ff}
                            : sys_cfg_fb_i; // [RULE_14] [RULE_13]
      end
      sbc_regs_pkg::SEL_SCRATCH1: begin
        reply = last_rrs_ff ? {last_sel_ff, 2'h0, user_bits_one_ff}
                            : phy_ctl_fb_i; // [RULE_16] [RULE_10]
      end
      default: reply = 16'h0000;
    endcase
  end

  // Register writes on a completed frame only
  always_comb begin
    nxt_last_sel = last_sel_ff;
    nxt_last_rrs = last_rrs_ff;
    nxt_special = special_ff;
    nxt_user_bits_zero = user_bits_zero_ff;
    nxt_idc = idc_ff;
    nxt_user_bits_one = user_bits_one_ff;
    if (frame_ok) begin // [RULE_19]
      nxt_last_sel = sel;
      nxt_last_rrs = readback_source_select;
      case (sel)
        sbc_regs_pkg::SEL_SPECIAL: begin // [RULE_01]
          if (!nowr) begin // [RULE_03]
            // Reserved bits are dropped so they always read zero
            nxt_special = frame[11:0] & sbc_regs_pkg::SPECIAL_MASK;
          end
        end
        sbc_regs_pkg::SEL_SCRATCH0: begin
          if (!nowr) begin // [RULE_15]
            nxt_user_bits_zero = frame[10:0];
            nxt_idc = 1'b1; // [RULE_12]
          end
        end
        sbc_regs_pkg::SEL_SCRATCH1: begin
          if (!nowr) begin // [RULE_17]
            nxt_user_bits_one = frame[11:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Decoded outputs and LIN transmitter guard
  always_comb begin
    // Emulation mode mirrors diagnosis code, else normal enable
    if (special_ff[sbc_regs_pkg::ERROR_PIN_EMULATION_BIT]) begin
      nxt_en = (can_failure_diagnosis_code_s1_ff == sbc_regs_pkg::CAN_FAILURE_DIAGNOSIS_CODE_OK); // [RULE_06]
    end else begin
      nxt_en = can_s1_ff[1]; // [RULE_07]
    end
    nxt_swdev = special_ff[sbc_regs_pkg::SWDEV_BIT]; // [RULE_05]
    case (special_ff[sbc_regs_pkg::WATCHDOG_PRESCALER_FIELD_HI:sbc_regs_pkg::WATCHDOG_PRESCALER_FIELD_LO])
      2'h0: nxt_wd = sbc_regs_pkg::WATCHDOG_PRESCALER_FIELD_X1; // [RULE_08]
      2'h1: nxt_wd = sbc_regs_pkg::WATCHDOG_PRESCALER_FIELD_X1P5;
      2'h2: nxt_wd = sbc_regs_pkg::WATCHDOG_PRESCALER_FIELD_X2P5;
      2'h3: nxt_wd = sbc_regs_pkg::WATCHDOG_PRESCALER_FIELD_X3P5;
      default: nxt_wd = sbc_regs_pkg::WATCHDOG_PRESCALER_FIELD_X1;
    endcase
    case (special_ff[sbc_regs_pkg::V1TH_HI:sbc_regs_pkg::V1TH_LO])
      2'h1: nxt_v1 = sbc_regs_pkg::V1TH_80; // [RULE_09]
      2'h2: nxt_v1 = sbc_regs_pkg::V1TH_70;
      default: nxt_v1 = sbc_regs_pkg::V1TH_90;
    endcase
    // Failure blocks the driver; traffic or a set-then-clear lifts it
    nxt_lin_blk = lin_blk_ff;
    nxt_ltc_seen = ltc_seen_ff;
    if (ltc_s_ff[1]) begin
      nxt_ltc_seen = 1'b1;
    end
    if (rxv_s_ff[1] || (ltc_seen_ff && !ltc_s_ff[1])) begin
      nxt_lin_blk = 1'b0; // [RULE_18]
      nxt_ltc_seen = 1'b0;
    end
    // Failure wins over recovery in the same cycle
    if (fail_s_ff[1]) begin
      nxt_lin_blk = 1'b1; // [RULE_18]
    end
    nxt_lin_en = !lin_blk_ff && !ltc_s_ff[1];
  end

  // Registers; ID code loaded at power-up with flag clear
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      last_sel_ff <= 2'h0;
      last_rrs_ff <= 1'b0;
      special_ff <= sbc_regs_pkg::SPECIAL_RST;
      user_bits_zero_ff <= ID_CODE; // [RULE_11]
      idc_ff <= 1'b0; // [RULE_11]
      user_bits_one_ff <= sbc_regs_pkg::SCRATCH_RST;
      en_ff <= 1'b0;
      swdev_ff <= 1'b0;
      wd_ff <= sbc_regs_pkg::WATCHDOG_PRESCALER_FIELD_X1;
      v1_ff <= sbc_regs_pkg::V1TH_90;
      lin_blk_ff <= 1'b0;
      ltc_seen_ff <= 1'b0;
      lin_en_ff <= 1'b0;
      can_s0_ff <= 2'h0;
      can_s1_ff <= 2'h0;
      can_failure_diagnosis_code_s0_ff <= 4'h0;
      can_failure_diagnosis_code_s1_ff <= 4'h0;
      ltc_s_ff <= 2'h0;
      fail_s_ff <= 2'h0;
      rxv_s_ff <= 2'h0;
    end else begin
      last_sel_ff <= nxt_last_sel;
      last_rrs_ff <= nxt_last_rrs;
      special_ff <= nxt_special;
      user_bits_zero_ff <= nxt_user_bits_zero;
      idc_ff <= nxt_idc;
      user_bits_one_ff <= nxt_user_bits_one;
      en_ff <= nxt_en;
      swdev_ff <= nxt_swdev;
      wd_ff <= nxt_wd;
      v1_ff <= nxt_v1;
      lin_blk_ff <= nxt_lin_blk;
      ltc_seen_ff <= nxt_ltc_seen;
      lin_en_ff <= nxt_lin_en;
      // Pin inputs pass two flip-flops; en_normal_i passes three
      can_s0_ff <= {can_s0_ff[0], en_normal_i};
      can_s1_ff <= can_s0_ff;
      can_failure_diagnosis_code_s0_ff <= can_failure_diagnosis_code_i;
      can_failure_diagnosis_code_s1_ff <= can_failure_diagnosis_code_s0_ff;
      ltc_s_ff <= {ltc_s_ff[0], lin_tx_disable_bit_i};
      fail_s_ff <= {fail_s_ff[0], lin_if_fail_i};
      rxv_s_ff <= {rxv_s_ff[0], lin_rx_valid_i};
    end
  end

  assign en_pin_o = en_ff;
  assign sw_dev_mode_init_o = swdev_ff;
  assign wd_scale_half_o = wd_ff;
  assign v1_thresh_tenth_o = v1_ff;
  assign lin_tx_enable_o = lin_en_ff;
endmodule : sbc_special_gp_regs

/* sbc_special_gp_regs_assertions.sv */
// Checker for the special mode and scratch bank pins
`timescale 1ns/1ps
module sbc_special_gp_regs_assertions (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic csn_i,
  input wire logic [3:0] can_failure_diagnosis_code_i,
  input wire logic en_normal_i,
  input wire logic lin_tx_disable_bit_i,
  input wire logic lin_if_fail_i,
  input wire logic lin_rx_valid_i,
  input wire logic en_pin_o,
  input wire logic sw_dev_mode_init_o,
  input wire logic [2:0] wd_scale_half_o,
  input wire logic [3:0] v1_thresh_tenth_o,
  input wire logic lin_tx_enable_o
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Clean LIN traffic with no failure and no software disable
  sequence s_lin_clean;
    (!lin_if_fail_i && !lin_tx_disable_bit_i && lin_rx_valid_i)[*4];
  endsequence
  // Idle link long enough for any pending update to land
  sequence s_idle;
    csn_i[*8];
  endsequence
  property p_wd_legal;
    wd_scale_half_o inside {3'h2, 3'h3, 3'h5, 3'h7};
  endproperty
  a_wd_legal: assert property (p_wd_legal)
    else $error("prescale code out of range");
  property p_v1_legal;
    v1_thresh_tenth_o inside {4'h7, 4'h8, 4'h9};
  endproperty
  a_v1_legal: assert property (p_v1_legal)
    else $error("threshold out of range");
  // Both pin modes agree on high here, so the mode need not be known
  property p_en_high;
    (can_failure_diagnosis_code_i == 4'h0 && en_normal_i)[*6]
      |-> ##[0:2] en_pin_o;
  endproperty
  a_en_high: assert property (p_en_high)
    else $error("enable pin not high");
  property p_en_low;
    (can_failure_diagnosis_code_i != 4'h0 && !en_normal_i)[*6]
      |-> ##[0:2] !en_pin_o;
  endproperty
  a_en_low: assert property (p_en_low)
    else $error("enable pin not low");
  property p_lin_fail;
    lin_if_fail_i[*2] |-> ##[1:5] !lin_tx_enable_o;
  endproperty
  a_lin_fail: assert property (p_lin_fail)
    else $error("transmitter kept on after failure");
  property p_lin_sw_off;
    lin_tx_disable_bit_i[*4] |-> ##[0:3] !lin_tx_enable_o;
  endproperty
  a_lin_sw_off: assert property (p_lin_sw_off)
    else $error("transmitter on while disabled");
  property p_lin_recover;
    s_lin_clean |-> ##[0:4] lin_tx_enable_o;
  endproperty
  a_lin_recover: assert property (p_lin_recover)
    else $error("transmitter not recovered");
  property p_no_frame;
    s_idle |-> $stable(wd_scale_half_o) && $stable(v1_thresh_tenth_o)
      && $stable(sw_dev_mode_init_o);
  endproperty
  a_no_frame: assert property (p_no_frame)
    else $error("settings moved without a frame");
endmodule : sbc_special_gp_regs_assertions

/* sbc_host_model.sv */
// Host model that clocks serial frames into the register bank
`timescale 1ns/1ps
module sbc_host_model (
  input wire logic core_clk_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic csn_o,
  output logic mosi_o
);
  // Link clock stands low and the device is deselected outside frames
  initial begin
    sck_o = 1'b0;
    csn_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Half a link period: four core clocks, so 400 ns per bit
  task automatic half;
    repeat (4) @(negedge core_clk_i);
  endtask : half
  // Sends n bits MSB first and collects the reply on rising link edges
  task automatic frame(input logic [15:0] w, input int n,
                       output logic [15:0] r);
    r = 16'h0000;
    csn_o = 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      mosi_o = w[15 - i];
      half();
      sck_o = 1'b1;
      r = {r[14:0], miso_i};
      half();
      sck_o = 1'b0;
    end
    half();
    csn_o = 1'b1;
    // Released data shows the inverse so a stale bit never looks valid
    mosi_o = ~mosi_o;
    half();
    half();
  endtask : frame
endmodule : sbc_host_model

/* sbc_special_gp_regs_bench.sv */
// Self-checking bench for the special mode and scratch bank
`timescale 1ns/1ps
module sbc_special_gp_regs_bench;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic sck, csn, mosi, miso, en_pin, sw, lin_en, en_norm, lin_tx_disable_bit, lf, lrx;
  logic [3:0] can, v1;
  logic [2:0] wd;
  logic [15:0] rd, expv, w;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  // Expected prescale and threshold outputs per field code
  logic [2:0] wd_t [4] = '{3'h2, 3'h3, 3'h5, 3'h7};
  logic [3:0] v1_t [4] = '{4'h9, 4'h8, 4'h7, 4'h9};
  always #25 core_clk_i = ~core_clk_i;
  sbc_host_model sbc_host_model_inst (.core_clk_i(core_clk_i),
    .miso_i(miso), .sck_o(sck), .csn_o(csn), .mosi_o(mosi));
  sbc_special_gp_regs sbc_special_gp_regs_inst (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .sck_i(sck), .csn_i(csn), .mosi_i(mosi),
    .int_en_fb_i(16'h0a5c), .sys_cfg_fb_i(16'h0c3d),
    .phy_ctl_fb_i(16'h0e1f), .can_failure_diagnosis_code_i(can),
    .en_normal_i(en_norm), .lin_tx_disable_bit_i(lin_tx_disable_bit),
    .lin_if_fail_i(lf), .lin_rx_valid_i(lrx), .miso_o(miso),
    .en_pin_o(en_pin), .sw_dev_mode_init_o(sw), .wd_scale_half_o(wd),
    .v1_thresh_tenth_o(v1), .lin_tx_enable_o(lin_en));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic end_of_test;
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc
  // Reply of each frame belongs to the previous valid frame
  task automatic go(input logic [15:0] fw, input logic [15:0] nxt);
    sbc_host_model_inst.frame(fw, 16, rd);
    check(rd, expv);
    expv = nxt;
  endtask : go
  // Cuts a hang short well past the expected run length
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    {can, en_norm, lin_tx_disable_bit, lf, lrx} = 8'h00;
    expv = 16'h0000;
    cyc(2);
    arst_n_i = 1'b1;
    cyc(6);
    check(16'(lin_en), 16'h0001);
    go(16'hb000, 16'h805a);
    go(16'ha123, 16'h8923);
    go(16'hb000, 16'h8923);
    go(16'h7000, 16'h4000);
    go(16'h5000, 16'h0a5c);
    go(16'h6fff, 16'h4378);
    go(16'h7000, 16'h4378);
    check(16'({sw, wd, v1}), 16'h00f9);
    for (int c = 0; c < 4; c++) begin
      w = 16'h6000 | 16'(c << 5) | 16'(c << 3);
      go(w, {4'h4, sbc_regs_pkg::SPECIAL_MASK & w[11:0]});
      check(16'({sw, wd, v1}), 16'({1'b0, wd_t[c], v1_t[c]}));
    end
    go(16'h7200, 16'h4078);
    sbc_host_model_inst.frame(16'h6200, 15, rd);
    check(16'({sw, wd, v1}), 16'h0079);
    go(16'h6100, 16'h4100);
    cyc(8);
    check(16'(en_pin), 16'h0001);
    can = 4'h3;
    cyc(8);
    check(16'(en_pin), 16'h0000);
    go(16'h6000, 16'h4000);
    en_norm = 1'b1;
    cyc(8);
    check(16'(en_pin), 16'h0001);
    go(16'heabc, 16'hcabc);
    go(16'hf000, 16'hcabc);
    go(16'hd000, 16'h0e1f);
    go(16'h9000, 16'h0c3d);
    go(16'hb000, 16'h8923);
    go(16'hb000, 16'h8923);
    lf = 1'b1;
    cyc(2);
    lf = 1'b0;
    cyc(8);
    check(16'(lin_en), 16'h0000);
    lrx = 1'b1;
    cyc(4);
    lrx = 1'b0;
    cyc(8);
    check(16'(lin_en), 16'h0001);
    lf = 1'b1;
    cyc(2);
    {lf, lin_tx_disable_bit} = 2'h1;
    cyc(8);
    check(16'(lin_en), 16'h0000);
    lin_tx_disable_bit = 1'b0;
    cyc(8);
    check(16'(lin_en), 16'h0001);
    // Clean diagnosis with the normal enable high: pin must stay high
    can = 4'h0;
    cyc(8);
    check(16'(en_pin), 16'h0001);
    end_of_test();
  end
endmodule : sbc_special_gp_regs_bench
bind sbc_special_gp_regs sbc_special_gp_regs_assertions chk_inst (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .csn_i(csn_i),
  .can_failure_diagnosis_code_i(can_failure_diagnosis_code_i),
  .en_normal_i(en_normal_i), .lin_tx_disable_bit_i(lin_tx_disable_bit_i),
  .lin_if_fail_i(lin_if_fail_i), .lin_rx_valid_i(lin_rx_valid_i),
  .en_pin_o(en_pin_o), .sw_dev_mode_init_o(sw_dev_mode_init_o),
  .wd_scale_half_o(wd_scale_half_o), .v1_thresh_tenth_o(v1_thresh_tenth_o),
  .lin_tx_enable_o(lin_tx_enable_o));
